// >>> src/fspes_pkg.sv
// package for the flash self-program entry service
package fspes_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int RAM_W = 8;
	localparam logic [7:0] EP_PAGE_ERASE = 8'h17;
	localparam logic [7:0] EP_MASS_ERASE = 8'h1A;
	localparam logic [7:0] EP_READ_BYTE = 8'h11;
	localparam logic [7:0] EP_BLOCK_READ = 8'h26;
	localparam logic [7:0] EP_WRITE_BYTE = 8'h14;
	localparam logic [7:0] EP_BLOCK_WRITE = 8'h23;
	localparam logic [7:0] EP_EXIT = 8'h62;
	localparam logic [7:0] EP_SERIAL_ISP = 8'h00;
	localparam logic [7:0] MASS_CONFIRM = 8'h55;
	localparam logic [7:0] UNLOCK_KEY = 8'h98;
	localparam logic [2:0] KEY_WINDOW_CYC = 3'h6;
	localparam logic [7:0] BLOCK_WRITE_MAX = 8'h10;
	localparam int BOUNDARY_BYTES = 64;
	localparam logic [7:0] RESULT_RST = 8'h00;
	typedef enum logic [2:0] {
		FSPES_RES_NONE,
		FSPES_RES_RETURN,
		FSPES_RES_REJECT,
		FSPES_RES_RESET,
		FSPES_RES_SERIAL_ISP
	} fspes_result_e;
endpackage // fspes_pkg

// >>> src/fspes_if.sv
// interface joining the calling core and the entry service
`timescale 1ns/1ps
interface fspes_if;
	logic        key_wr;
	logic [7:0]  key_val;
	logic        call_req;
	logic [7:0]  entry_point;
	logic [7:0]  acc;
	logic [7:0]  flash_addr_high;
	logic [7:0]  flash_addr_low;
	logic [7:0]  write_data_byte;
	logic [7:0]  block_byte_count;
	logic [7:0]  index_ptr;
	logic [7:0]  write_pulse_timing;
	logic        busy;
	logic        done;
	logic [2:0]  result;
	logic [7:0]  read_result_byte;
	logic        ram_we;
	logic        ram_re;
	logic [7:0]  ram_addr;
	logic [7:0]  ram_wdata;
	logic [7:0]  ram_rdata;
	modport device (
		input  key_wr, key_val, call_req, entry_point, acc,
		input  flash_addr_high, flash_addr_low, write_data_byte,
		input  block_byte_count, index_ptr, write_pulse_timing, ram_rdata,
		output busy, done, result, read_result_byte,
		output ram_we, ram_re, ram_addr, ram_wdata
	);
	modport caller (
		output key_wr, key_val, call_req, entry_point, acc,
		output flash_addr_high, flash_addr_low, write_data_byte,
		output block_byte_count, index_ptr, write_pulse_timing, ram_rdata,
		input  busy, done, result, read_result_byte,
		input  ram_we, ram_re, ram_addr, ram_wdata
	);
endinterface // fspes_if

// >>> src/fspes_device.sv
// flash self-program entry service: device end
`timescale 1ns/1ps
module fspes_device (
	// clock and reset
	input  wire logic        mclk_in,
	input  wire logic        resetn_in,
	// core side
	fspes_if.device          cpu,
	// flash array side
	output logic             fl_page_erase_out,
	output logic             fl_mass_erase_out,
	output logic             fl_read_out,
	output logic             fl_write_out,
	output logic [15:0]      fl_addr_out,
	output logic [7:0]       fl_wdata_out,
	output logic [7:0]       fl_pulse_timing_out,
	input  wire logic [7:0]  fl_rdata_in,
	input  wire logic        fl_ready_in,
	// mode outputs and serial exit input
	output logic             serial_isp_out,
	output logic             device_reset_out,
	input  wire logic        serial_exit_in
);
	typedef enum logic [3:0] {
		FSPES_IDLE, FSPES_ERASE, FSPES_RD, FSPES_RD_WAIT, FSPES_WR,
		FSPES_BR_RD, FSPES_BR_WAIT, FSPES_BW_FETCH, FSPES_BW_WR,
		FSPES_WAIT, FSPES_FINISH, FSPES_ISP, FSPES_BW_LAT
	} fspes_state_e;

	fspes_state_e state_r;
	logic [2:0]   key_age_r;
	logic         key_live_r;
	logic [15:0]  addr_r;
	logic [7:0]   ptr_r;
	logic [7:0]   count_r;
	logic         mass_r;
	fspes_pkg::fspes_result_e res_r;

	// unlock window tracking
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			key_live_r <= 1'b0;
			key_age_r <= 3'h0;
		end else if (cpu.key_wr) begin
			key_live_r <= (cpu.key_val == fspes_pkg::UNLOCK_KEY);
			key_age_r <= 3'h0;
		end else if (cpu.call_req) begin
			key_live_r <= 1'b0;
		end else if (key_live_r) begin
			if (key_age_r >= fspes_pkg::KEY_WINDOW_CYC - 3'h1)
				key_live_r <= 1'b0;
			key_age_r <= key_age_r + 3'h1;
		end
	end

	// service sequencer
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_r <= FSPES_IDLE;
			addr_r <= 16'h0000;
			ptr_r <= 8'h00;
			count_r <= 8'h00;
			mass_r <= 1'b0;
			res_r <= fspes_pkg::FSPES_RES_NONE;
			cpu.busy <= 1'b0;
			cpu.done <= 1'b0;
			cpu.result <= fspes_pkg::FSPES_RES_NONE;
			cpu.read_result_byte <= fspes_pkg::RESULT_RST;
			cpu.ram_we <= 1'b0;
			cpu.ram_re <= 1'b0;
			cpu.ram_addr <= 8'h00;
			cpu.ram_wdata <= 8'h00;
			fl_page_erase_out <= 1'b0;
			fl_mass_erase_out <= 1'b0;
			fl_read_out <= 1'b0;
			fl_write_out <= 1'b0;
			fl_addr_out <= 16'h0000;
			fl_wdata_out <= 8'h00;
			fl_pulse_timing_out <= 8'h00;
			serial_isp_out <= 1'b0;
			device_reset_out <= 1'b0;
		end else begin
			cpu.done <= 1'b0;
			cpu.ram_we <= 1'b0;
			cpu.ram_re <= 1'b0;
			fl_page_erase_out <= 1'b0;
			fl_mass_erase_out <= 1'b0;
			fl_read_out <= 1'b0;
			fl_write_out <= 1'b0;
			device_reset_out <= 1'b0;
			case (state_r)
			FSPES_IDLE: begin
				if (cpu.call_req) begin
					addr_r <= {cpu.flash_addr_high, cpu.flash_addr_low};
					ptr_r <= cpu.index_ptr;
					count_r <= cpu.block_byte_count;
					fl_pulse_timing_out <= cpu.write_pulse_timing;
					mass_r <= 1'b0;
					cpu.busy <= 1'b1;
					res_r <= fspes_pkg::FSPES_RES_RETURN;
					if (!key_live_r) begin
						res_r <= fspes_pkg::FSPES_RES_REJECT;
						state_r <= FSPES_FINISH;
					end else if (cpu.entry_point == fspes_pkg::EP_PAGE_ERASE)
						state_r <= FSPES_ERASE;
					else if (cpu.entry_point == fspes_pkg::EP_MASS_ERASE) begin
						if (cpu.acc == fspes_pkg::MASS_CONFIRM) begin
							mass_r <= 1'b1;
							state_r <= FSPES_ERASE;
						end else begin
							res_r <= fspes_pkg::FSPES_RES_REJECT;
							state_r <= FSPES_FINISH;
						end
					end else if (cpu.entry_point == fspes_pkg::EP_READ_BYTE)
						state_r <= FSPES_RD;
					else if (cpu.entry_point == fspes_pkg::EP_BLOCK_READ)
						state_r <= FSPES_BR_RD;
					else if (cpu.entry_point == fspes_pkg::EP_WRITE_BYTE)
						state_r <= FSPES_WR;
					else if (cpu.entry_point == fspes_pkg::EP_BLOCK_WRITE) begin
						if (cpu.block_byte_count > fspes_pkg::BLOCK_WRITE_MAX)
							count_r <= fspes_pkg::BLOCK_WRITE_MAX;
						state_r <= FSPES_BW_FETCH;
					end else if (cpu.entry_point == fspes_pkg::EP_EXIT) begin
						res_r <= fspes_pkg::FSPES_RES_RESET;
						state_r <= FSPES_FINISH;
					end else if (cpu.entry_point == fspes_pkg::EP_SERIAL_ISP) begin
						res_r <= fspes_pkg::FSPES_RES_SERIAL_ISP;
						state_r <= FSPES_FINISH;
					end else begin
						res_r <= fspes_pkg::FSPES_RES_REJECT;
						state_r <= FSPES_FINISH;
					end
				end
			end
			FSPES_ERASE: begin
				fl_addr_out <= addr_r;
				fl_page_erase_out <= !mass_r;
				fl_mass_erase_out <= mass_r;
				// single accesses never fall into the block loop
				count_r <= 8'h00;
				if (mass_r)
					res_r <= fspes_pkg::FSPES_RES_SERIAL_ISP;
				state_r <= FSPES_WAIT;
			end
			FSPES_RD: begin
				fl_addr_out <= addr_r;
				fl_read_out <= 1'b1;
				state_r <= FSPES_RD_WAIT;
			end
			FSPES_RD_WAIT: begin
				if (fl_ready_in) begin
					cpu.read_result_byte <= fl_rdata_in;
					state_r <= FSPES_FINISH;
				end
			end
			FSPES_WR: begin
				fl_addr_out <= addr_r;
				fl_wdata_out <= cpu.write_data_byte;
				count_r <= 8'h00;
				fl_write_out <= 1'b1;
				state_r <= FSPES_WAIT;
			end
			FSPES_BR_RD: begin
				if (count_r == 8'h00)
					state_r <= FSPES_FINISH;
				else begin
					fl_addr_out <= addr_r;
					fl_read_out <= 1'b1;
					state_r <= FSPES_BR_WAIT;
				end
			end
			FSPES_BR_WAIT: begin
				if (fl_ready_in) begin
					cpu.ram_addr <= ptr_r;
					cpu.ram_wdata <= fl_rdata_in;
					cpu.ram_we <= 1'b1;
					ptr_r <= ptr_r + 8'h01;
					addr_r <= addr_r + 16'h0001;
					count_r <= count_r - 8'h01;
					state_r <= FSPES_BR_RD;
				end
			end
			FSPES_BW_FETCH: begin
				if (count_r == 8'h00)
					state_r <= FSPES_FINISH;
				else begin
					cpu.ram_addr <= ptr_r;
					cpu.ram_re <= 1'b1;
					state_r <= FSPES_BW_LAT;
				end
			end
			// ram data arrives one cycle after the read strobe
			FSPES_BW_LAT: state_r <= FSPES_BW_WR;
			FSPES_BW_WR: begin
				fl_addr_out <= addr_r;
				fl_wdata_out <= cpu.ram_rdata;
				fl_write_out <= 1'b1;
				ptr_r <= ptr_r + 8'h01;
				addr_r <= addr_r + 16'h0001;
				count_r <= count_r - 8'h01;
				state_r <= FSPES_WAIT;
			end
			FSPES_WAIT: begin
				if (fl_ready_in)
					state_r <= (count_r != 8'h00) ? FSPES_BW_FETCH : FSPES_FINISH;
			end
			FSPES_FINISH: begin
				cpu.busy <= 1'b0;
				cpu.done <= 1'b1;
				cpu.result <= res_r;
				if (res_r == fspes_pkg::FSPES_RES_RESET)
					device_reset_out <= 1'b1;
				if (res_r == fspes_pkg::FSPES_RES_SERIAL_ISP) begin
					serial_isp_out <= 1'b1;
					cpu.busy <= 1'b1;
					state_r <= FSPES_ISP;
				end else
					state_r <= FSPES_IDLE;
			end
			FSPES_ISP: begin
				if (serial_exit_in) begin
					serial_isp_out <= 1'b0;
					device_reset_out <= 1'b1;
					cpu.busy <= 1'b0;
					state_r <= FSPES_IDLE;
				end
			end
			default: state_r <= FSPES_IDLE;
			endcase
		end
	end
endmodule // fspes_device

// >>> src/fspes_caller.sv
// calling-core end: loads parameters, key, then issues the call
`timescale 1ns/1ps
module fspes_caller (
	// clock and reset
	input  wire logic        mclk_in,
	input  wire logic        resetn_in,
	// user request, ram data and status outputs
	input  wire logic        start_in,
	input  wire logic [7:0]  entry_in,
	input  wire logic [7:0]  acc_in,
	input  wire logic [15:0] addr_in,
	input  wire logic [7:0]  wdata_in,
	input  wire logic [7:0]  count_in,
	input  wire logic [7:0]  ptr_in,
	input  wire logic [7:0]  timing_in,
	input  wire logic [7:0]  key_in,
	input  wire logic [7:0]  ram_rdata_in,
	output logic             busy_out,
	output logic             done_out,
	output logic [2:0]       result_out,
	output logic [7:0]       rdata_out,
	// link
	fspes_if.caller          dev
);
	typedef enum logic [1:0] {
		FSPES_C_IDLE, FSPES_C_KEY, FSPES_C_CALL, FSPES_C_WAIT
	} fspes_cstate_e;
	fspes_cstate_e state_r;

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_r <= FSPES_C_IDLE;
			dev.key_wr <= 1'b0;
			dev.key_val <= 8'h00;
			dev.call_req <= 1'b0;
			dev.entry_point <= 8'h00;
			dev.acc <= 8'h00;
			dev.flash_addr_high <= 8'h00;
			dev.flash_addr_low <= 8'h00;
			dev.write_data_byte <= 8'h00;
			dev.block_byte_count <= 8'h00;
			dev.index_ptr <= 8'h00;
			dev.write_pulse_timing <= 8'h00;
			busy_out <= 1'b0;
			done_out <= 1'b0;
			result_out <= 3'h0;
			rdata_out <= 8'h00;
		end else begin
			dev.key_wr <= 1'b0;
			dev.call_req <= 1'b0;
			done_out <= 1'b0;
			case (state_r)
			FSPES_C_IDLE: if (start_in) begin
				dev.flash_addr_high <= addr_in[15:8];
				dev.flash_addr_low <= addr_in[7:0];
				dev.acc <= acc_in;
				dev.write_data_byte <= wdata_in;
				dev.block_byte_count <= count_in;
				dev.index_ptr <= ptr_in;
				dev.write_pulse_timing <= timing_in;
				dev.entry_point <= entry_in;
				busy_out <= 1'b1;
				state_r <= FSPES_C_KEY;
			end
			FSPES_C_KEY: begin
				dev.key_wr <= 1'b1;
				dev.key_val <= key_in;
				state_r <= FSPES_C_CALL;
			end
			FSPES_C_CALL: begin
				dev.call_req <= 1'b1;
				state_r <= FSPES_C_WAIT;
			end
			FSPES_C_WAIT: if (dev.done) begin
				result_out <= dev.result;
				rdata_out <= dev.read_result_byte;
				done_out <= 1'b1;
				busy_out <= 1'b0;
				state_r <= FSPES_C_IDLE;
			end
			default: state_r <= FSPES_C_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in)
			dev.ram_rdata <= 8'h00;
		else
			dev.ram_rdata <= ram_rdata_in;
	end
endmodule // fspes_caller

// >>> testbench/fspes_assertions.sv
// assertions on the link between calling core and entry service
`timescale 1ns/1ps
module fspes_assertions (
	// clock and reset
	input wire logic       mclk_in,
	input wire logic       resetn_in,
	// link signals
	input wire logic       key_wr,
	input wire logic [7:0] key_val,
	input wire logic       call_req,
	input wire logic [7:0] entry_point,
	input wire logic [7:0] acc,
	input wire logic [7:0] index_ptr,
	input wire logic       busy,
	input wire logic       done,
	input wire logic [2:0] result,
	input wire logic       ram_we,
	input wire logic       ram_re,
	input wire logic [7:0] ram_addr
);
	logic [2:0] key_age_r;
	logic [7:0] ram_exp_r;
	logic       tk;
	logic       ok;
	assign tk = call_req && !busy;
	assign ok = key_age_r != 3'h0 && key_age_r != 3'h7;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!resetn_in);
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in)
			key_age_r <= 3'h0;
		else if (key_wr)
			key_age_r <= {2'h0, key_val == fspes_pkg::UNLOCK_KEY};
		else if (tk)
			key_age_r <= 3'h0;
		else if (ok)
			key_age_r <= key_age_r + 3'h1;
	end
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in)
			ram_exp_r <= 8'h00;
		else if (tk)
			ram_exp_r <= index_ptr;
		else if (ram_we || ram_re)
			ram_exp_r <= ram_addr + 8'h01;
	end
	AST_NO_KEY: assert property (
		tk && !ok |-> ##2 (done && result == fspes_pkg::FSPES_RES_REJECT))
		else $error("call without key not refused");
	AST_MASS_BAD: assert property (
		tk && ok && entry_point == fspes_pkg::EP_MASS_ERASE &&
		acc != fspes_pkg::MASS_CONFIRM |->
		##2 (done && result == fspes_pkg::FSPES_RES_REJECT))
		else $error("mass erase without confirm not refused");
	AST_EXIT: assert property (
		tk && ok && entry_point == fspes_pkg::EP_EXIT |->
		##2 (done && result == fspes_pkg::FSPES_RES_RESET))
		else $error("exit call did not reset");
	AST_ISP: assert property (
		tk && ok && entry_point == fspes_pkg::EP_SERIAL_ISP |->
		##2 (done && result == fspes_pkg::FSPES_RES_SERIAL_ISP))
		else $error("serial mode call wrong answer");
	AST_ISP_BUSY: assert property (
		done && result == fspes_pkg::FSPES_RES_SERIAL_ISP |-> busy ##1 busy)
		else $error("serial mode left early");
	AST_READ: assert property (
		tk && ok && entry_point == fspes_pkg::EP_READ_BYTE |->
		##[4:40] (done && result == fspes_pkg::FSPES_RES_RETURN))
		else $error("read byte did not return");
	AST_DONE_PULSE: assert property (
		done |=> !done)
		else $error("done longer than one cycle");
	AST_RES_HOLD: assert property (
		!done |-> $stable(result))
		else $error("result changed without done");
	AST_RAM_ADDR: assert property (
		ram_we || ram_re |-> ram_addr == ram_exp_r)
		else $error("ram address not ascending from pointer");
	cover property (tk && ok && entry_point == fspes_pkg::EP_BLOCK_WRITE);
	cover property (ram_we);
	cover property (done && result == fspes_pkg::FSPES_RES_SERIAL_ISP);
endmodule // fspes_assertions

// >>> testbench/flash_self_program_entry_service_tb.sv
// bench driving the calling core end against the service end
`timescale 1ns/1ps
module flash_self_program_entry_service_tb;
	logic        mclk_in = 1'b0;
	logic        resetn_in = 1'b0;
	logic        start_in = 1'b0;
	logic [7:0]  entry_in = 8'h00;
	logic [7:0]  acc_in = 8'h00;
	logic [15:0] addr_in = 16'h0000;
	logic [7:0]  wdata_in = 8'h00;
	logic [7:0]  count_in = 8'h00;
	logic [7:0]  ptr_in = 8'h00;
	logic [7:0]  ram_rdata_in;
	logic        busy_out, done_out, fl_pe, fl_me, fl_rd, fl_wr, isp, dres;
	logic [2:0]  result_out;
	logic [7:0]  rdata_out, fl_wdata, fl_rdata;
	logic [15:0] fl_addr;
	logic        fl_ready = 1'b1;
	logic        serial_exit = 1'b0;
	logic [7:0]  key_in = fspes_pkg::UNLOCK_KEY;
	logic [7:0]  fl_tim;
	int          n_dres = 0;
	logic [1:0]  slow = 2'h0;
	logic [7:0]  fl_mem [256];
	logic [7:0]  ram [256];
	int          n_mismatch = 0;
	int          n_compared = 0;
	int          i;
	int          j;
	fspes_if bus ();
	fspes_caller i_fspes_caller (.mclk_in(mclk_in), .resetn_in(resetn_in),
		.start_in(start_in), .entry_in(entry_in), .acc_in(acc_in),
		.addr_in(addr_in), .wdata_in(wdata_in), .count_in(count_in),
		.ptr_in(ptr_in), .timing_in(8'h20), .key_in(key_in),
		.ram_rdata_in(ram_rdata_in),
		.busy_out(busy_out), .done_out(done_out), .result_out(result_out),
		.rdata_out(rdata_out), .dev(bus.caller));
	fspes_device i_fspes_device (.mclk_in(mclk_in), .resetn_in(resetn_in),
		.cpu(bus.device), .fl_page_erase_out(fl_pe), .fl_mass_erase_out(fl_me),
		.fl_read_out(fl_rd), .fl_write_out(fl_wr), .fl_addr_out(fl_addr),
		.fl_wdata_out(fl_wdata), .fl_pulse_timing_out(fl_tim),
		.fl_rdata_in(fl_rdata),
		.fl_ready_in(fl_ready), .serial_isp_out(isp), .device_reset_out(dres),
		.serial_exit_in(serial_exit));
	fspes_assertions i_fspes_assertions (.mclk_in(mclk_in),
		.resetn_in(resetn_in), .key_wr(bus.key_wr), .key_val(bus.key_val),
		.call_req(bus.call_req), .entry_point(bus.entry_point), .acc(bus.acc),
		.index_ptr(bus.index_ptr), .busy(bus.busy), .done(bus.done),
		.result(bus.result), .ram_we(bus.ram_we), .ram_re(bus.ram_re),
		.ram_addr(bus.ram_addr));
	always #2.5 mclk_in = ~mclk_in;
	// counts device reset pulses
	always @(posedge mclk_in)
		if (dres === 1'b1)
			n_dres <= n_dres + 1;
	assign ram_rdata_in = ram[bus.ram_addr];
	assign fl_rdata = fl_mem[fl_addr[7:0]];
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// flash array model, slow to report ready after each access
	always @(posedge mclk_in) begin
		if (fl_pe || fl_me || fl_rd || fl_wr) begin
			slow <= 2'h2;
			fl_ready <= 1'b0;
		end else if (slow != 2'h0) begin
			slow <= slow - 2'h1;
			fl_ready <= slow == 2'h1;
		end
		if (fl_wr) begin
			fl_mem[fl_addr[7:0]] <= fl_wdata;
			check(fl_addr[15:8], 8'h12);
		end
		if (fl_pe)
			for (j = 0; j < 64; j++)
				fl_mem[{fl_addr[7:6], j[5:0]}] <= 8'hFF;
		if (fl_me)
			for (j = 0; j < 256; j++)
				fl_mem[j] <= 8'hFF;
		if (bus.ram_we)
			ram[bus.ram_addr] <= bus.ram_wdata;
	end
	task automatic reset;
		resetn_in <= 1'b0;
		repeat (6) @(posedge mclk_in);
		resetn_in <= 1'b1;
	endtask
	task automatic wait_for(ref logic sig);
		int k;
		k = 0;
		do begin
			@(posedge mclk_in);
			#1;
			k++;
		end while (sig !== 1'b1 && k < 400);
		if (k >= 400) begin
			n_mismatch++;
			test_done;
		end
	endtask
	task automatic op(input logic [7:0] ep, input logic [15:0] ad,
		input logic [7:0] wd = 8'h00, input logic [7:0] cnt = 8'h00,
		input logic [7:0] p = 8'h00, input logic [7:0] a = 8'h00,
		input logic [2:0] exp = fspes_pkg::FSPES_RES_RETURN);
		@(posedge mclk_in);
		entry_in <= ep;
		addr_in <= ad;
		wdata_in <= wd;
		count_in <= cnt;
		ptr_in <= p;
		acc_in <= a;
		start_in <= 1'b1;
		@(posedge mclk_in);
		start_in <= 1'b0;
		wait_for(done_out);
		check(result_out, exp);
		$display("test done entry %h", ep);
	endtask
	task automatic leave_isp;
		@(posedge mclk_in);
		serial_exit <= 1'b1;
		wait_for(dres);
		@(posedge mclk_in);
		serial_exit <= 1'b0;
		reset;
	endtask
	initial begin
		for (i = 0; i < 256; i++) begin
			fl_mem[i] = 8'hFF;
			ram[i] = i[7:0] ^ 8'hA5;
		end
		reset;
		op(fspes_pkg::EP_WRITE_BYTE, 16'h1210, 8'h5A);
		check(fl_tim, 8'h20);
		op(fspes_pkg::EP_READ_BYTE, 16'h1210);
		check(rdata_out, 8'h5A);
		op(fspes_pkg::EP_BLOCK_WRITE, 16'h1220, 8'h00, 8'h10,
			8'h40);
		op(fspes_pkg::EP_BLOCK_READ, 16'h1220, 8'h00, 8'h10,
			8'h80);
		for (i = 0; i < 16; i++) begin
			check(fl_mem[32 + i], 8'(64 + i) ^ 8'hA5);
			check(ram[128 + i], 8'(64 + i) ^ 8'hA5);
		end
		check(fl_mem[8'h30], 8'hFF);
		op(fspes_pkg::EP_BLOCK_WRITE, 16'h1240, 8'h00, 8'h14,
			8'h60);
		check(fl_mem[8'h4F], 8'hCA);
		check(fl_mem[8'h50], 8'hFF);
		op(fspes_pkg::EP_BLOCK_WRITE, 16'h1238, 8'h00, 8'h00, 8'h50);
		check(fl_mem[8'h38], 8'hFF);
		op(fspes_pkg::EP_BLOCK_READ, 16'h1238, 8'h00, 8'h00, 8'hC0);
		check(ram[8'hC0], 8'h65);
		op(fspes_pkg::EP_PAGE_ERASE, 16'h1200);
		op(fspes_pkg::EP_READ_BYTE, 16'h1210);
		check(rdata_out, 8'hFF);
		op(fspes_pkg::EP_WRITE_BYTE, 16'h1290, 8'h3C, 8'h05);
		check(fl_mem[8'h91], 8'hFF);
		@(posedge mclk_in);
		key_in <= 8'h97;
		op(fspes_pkg::EP_WRITE_BYTE, 16'h1291, 8'h11, 8'h00, 8'h00, 8'h00,
			fspes_pkg::FSPES_RES_REJECT);
		check(fl_mem[8'h91], 8'hFF);
		@(posedge mclk_in);
		key_in <= fspes_pkg::UNLOCK_KEY;
		op(8'h33, 16'h1290, 8'h00, 8'h00, 8'h00, 8'h00, 3'h2);
		op(fspes_pkg::EP_MASS_ERASE, 16'h1290, 8'h00, 8'h00, 8'h00, 8'h54,
			fspes_pkg::FSPES_RES_REJECT);
		check(fl_mem[8'h90], 8'h3C);
		op(fspes_pkg::EP_EXIT, 16'h0000, 8'h00, 8'h00, 8'h00, 8'h00,
			fspes_pkg::FSPES_RES_RESET);
		check(n_dres, 16'h0001);
		reset;
		op(fspes_pkg::EP_SERIAL_ISP, 16'h0000, 8'h00, 8'h00, 8'h00, 8'h00,
			fspes_pkg::FSPES_RES_SERIAL_ISP);
		check(isp, 1'b1);
		leave_isp;
		check(n_dres, 16'h0002);
		op(fspes_pkg::EP_MASS_ERASE, 16'h0000, 8'h00, 8'h00, 8'h00, 8'h55,
			fspes_pkg::FSPES_RES_SERIAL_ISP);
		check(fl_mem[8'h90], 8'hFF);
		check(isp, 1'b1);
		leave_isp;
		check(n_dres, 16'h0003);
		test_done;
	end
endmodule // flash_self_program_entry_service_tb
